// ==== rtl/i2cr_pkg.sv ====
// constants, field layouts and carrier types of the serial register front end
package i2cr_pkg;

  localparam logic [7:0] OFS_STORE = 8'h15;
  localparam logic [7:0] OFS_RESTORE = 8'h16;
  localparam logic [7:0] OFS_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] OFS_TURN_ON_RISE_TIME = 8'h61;
  localparam logic [7:0] OFS_TURN_OFF_DELAY = 8'h64;
  localparam logic [7:0] OFS_TURN_OFF_FALL_TIME = 8'h65;
  localparam logic [7:0] OFS_TEMP = 8'h8d;
  localparam logic [7:0] OFS_SYS_CFG = 8'ha0;
  localparam logic [7:0] OFS_VID_ADDR = 8'ha1;
  localparam logic [7:0] OFS_TGT_ADDR = 8'ha2;
  localparam logic [7:0] OFS_VOUT_OFS = 8'ha8;
  localparam logic [7:0] OFS_LOCK = 8'hb1;
  localparam logic [7:0] OFS_VMAX_H = 8'hbd;
  localparam logic [7:0] OFS_VMAX_L = 8'hbe;
  localparam logic [7:0] OFS_PROTO = 8'hc2;

  // system_config_one field positions, then the protocol broadcast and store-go bits
  localparam int SC_ADDR_OVRD = 0;
  localparam int SC_VID_OVRD = 1;
  localparam int SC_FORCED_CONTINUOUS_FLAG = 2;
  localparam int SC_OUT_CTRL_LO = 3;
  localparam int SC_SOFT_STOP = 5;
  localparam int SC_RDY_DLY_LO = 6;
  localparam int PROTO_BCAST = 0;
  localparam int STORE_GO = 0;
  localparam logic [1:0] OUT_CTRL_STAGED = 2'h1;

  localparam logic [7:0] TEMP_OFFSET = 8'h28;
  localparam logic [6:0] STRAP_BASE_ADDR = 7'h70;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // passcodes: values arbitrary, applied in index order
  localparam int PASS_COUNT = 2;
  localparam logic [1:0][7:0] PASS_CODES = {8'ha5, 8'h5a};

  localparam int STORE_TIME_MS = 150;
  localparam int CLOCK_KHZ = 250000;
  localparam int STORE_CYCLES = STORE_TIME_MS * CLOCK_KHZ;
  localparam int INIT_WAIT = 2;

  typedef struct packed {
    logic [7:0] turn_on_delay;
    logic [7:0] turn_on_rise_time;
    logic [7:0] turn_off_delay;
    logic [7:0] turn_off_fall_time;
    logic [7:0] sys_cfg;
    logic [7:0] vid_addr;
    logic [7:0] tgt_addr;
    logic [7:0] vout_ofs;
    logic [7:0] vmax_h;
    logic [7:0] vmax_l;
    logic [7:0] proto;
  } i2cr_image_t;

  typedef struct packed {
    logic forced_continuous_flag;
    logic [1:0] output_control_field;
    logic soft_stop_enable;
    logic [1:0] ready_output_delay;
    logic [7:0] serial_vid_bus_address;
    logic broadcast_select;
    logic [7:0] output_voltage_offset;
  } i2cr_eff_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} i2cr_state_t;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} i2cr_phase_t;

endpackage

// ==== rtl/i2cr_top.sv ====
// serial target with write lock, staged fields and nonvolatile store control
`timescale 1ns/1ns
module i2cr_top #(
  parameter int STORE_CYCLES = i2cr_pkg::STORE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // converter side status
  input wire logic [3:0] strap_level,
  input wire logic switching_enabled,
  input wire logic always_on_mode,
  input wire logic [7:0] die_temp_c,
  // nonvolatile memory
  input wire i2cr_pkg::i2cr_image_t nvm_rd_image,
  output i2cr_pkg::i2cr_image_t nvm_wr_image,
  output logic nvm_wr_req,
  output logic nvm_busy,
  // configuration in use
  output i2cr_pkg::i2cr_image_t live_cfg,
  output i2cr_pkg::i2cr_eff_t eff_cfg,
  output logic [6:0] target_address,
  output logic vid_address_override_flag,
  output logic regs_unlocked
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus events
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  // 250 MHz oversamples even a 1 MHz bus clock by far
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_i};
      sda_s <= {sda_s[0], sda_i};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  assign scl_rise = scl_s[1] & ~scl_d;
  assign scl_fall = ~scl_s[1] & scl_d;
  assign bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign bus_stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // strap capture and power-on restore
  logic [3:0] strap_a;
  logic [3:0] strap_b;
  logic [1:0] init_cnt_r;
  logic init_go;
  always_ff @(posedge clock) begin
    if (srst) begin
      strap_a <= 4'h0;
      strap_b <= 4'h0;
    end else begin
      strap_a <= strap_level;
      strap_b <= strap_a;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      init_cnt_r <= 2'h0;
    end else if (init_cnt_r != 2'h3) begin
      init_cnt_r <= init_cnt_r + 2'h1;
    end
  end
  // one pulse once the strap has crossed both flops
  assign init_go = (init_cnt_r == 2'(i2cr_pkg::INIT_WAIT));

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  i2cr_pkg::i2cr_state_t state_r;
  i2cr_pkg::i2cr_phase_t phase_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] cmd_r;
  logic rw_r;
  logic mack_r;
  logic [7:0] rdata;
  logic rx_done;
  logic accept;
  logic wr_fire;
  logic addr_hit;
  assign rx_done = (state_r == i2cr_pkg::ST_RX) & scl_fall & (cnt_r == 4'h8);
  assign addr_hit = (rx_r[7:1] == target_address);
  assign wr_fire = rx_done & (phase_r == i2cr_pkg::PH_DATA) & ~rw_r & accept;
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= i2cr_pkg::ST_IDLE;
      phase_r <= i2cr_pkg::PH_ADDR;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      cmd_r <= 8'h00;
      rw_r <= 1'b0;
      mack_r <= 1'b1;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state_r <= i2cr_pkg::ST_RX;
      phase_r <= i2cr_pkg::PH_ADDR;
      cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_r <= i2cr_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_r)
        i2cr_pkg::ST_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            rx_r <= {rx_r[6:0], sda_s[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (rx_done) begin
            state_r <= i2cr_pkg::ST_ACK;
            case (phase_r)
              i2cr_pkg::PH_ADDR: begin
                rw_r <= rx_r[0];
                sda_oe <= addr_hit;
                if (!addr_hit) begin
                  state_r <= i2cr_pkg::ST_IDLE;
                end
              end
              i2cr_pkg::PH_CMD: begin
                cmd_r <= rx_r;
                sda_oe <= 1'b1;
              end
              default: begin
                // refused data bytes are answered with no drive
                sda_oe <= accept;
              end
            endcase
          end
        end
        i2cr_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            sda_oe <= 1'b0;
            if (phase_r == i2cr_pkg::PH_ADDR && rw_r) begin
              // read answered whatever the lock state
              state_r <= i2cr_pkg::ST_TX;
              sda_oe <= ~rdata[7];
              tx_r <= {rdata[6:0], 1'b0};
              cnt_r <= 4'h1;
            end else begin
              state_r <= i2cr_pkg::ST_RX;
              phase_r <= (phase_r == i2cr_pkg::PH_ADDR) ? i2cr_pkg::PH_CMD :
                         i2cr_pkg::PH_DATA;
            end
          end
        end
        i2cr_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              sda_oe <= 1'b0;
              state_r <= i2cr_pkg::ST_MACK;
            end else begin
              sda_oe <= ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        i2cr_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_r <= sda_s[1];
          end else if (scl_fall) begin
            if (!mack_r) begin
              state_r <= i2cr_pkg::ST_TX;
              sda_oe <= ~rdata[7];
              tx_r <= {rdata[6:0], 1'b0};
              cnt_r <= 4'h1;
            end else begin
              state_r <= i2cr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: only ever pulls low
  assign sda_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // write acceptance
  i2cr_pkg::i2cr_image_t work_r;
  logic unlocked_r;
  logic [1:0] pass_idx_r;
  logic busy;
  logic [25:0] busy_cnt_r;
  always_comb begin
    accept = 1'b0;
    case (cmd_r)
      i2cr_pkg::OFS_LOCK: accept = 1'b1;
      i2cr_pkg::OFS_STORE: accept = unlocked_r & ~busy;
      i2cr_pkg::OFS_RESTORE: accept = unlocked_r & ~busy & ~switching_enabled;
      i2cr_pkg::OFS_TURN_ON_DELAY,
      i2cr_pkg::OFS_TURN_ON_RISE_TIME,
      i2cr_pkg::OFS_TURN_OFF_DELAY,
      i2cr_pkg::OFS_TURN_OFF_FALL_TIME,
      i2cr_pkg::OFS_VMAX_H,
      i2cr_pkg::OFS_VMAX_L: accept = unlocked_r & ~switching_enabled;
      i2cr_pkg::OFS_SYS_CFG,
      i2cr_pkg::OFS_VID_ADDR,
      i2cr_pkg::OFS_TGT_ADDR,
      i2cr_pkg::OFS_VOUT_OFS,
      i2cr_pkg::OFS_PROTO: accept = unlocked_r;
      default: accept = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // passcode lock
  always_ff @(posedge clock) begin
    if (srst) begin
      unlocked_r <= 1'b0;
      pass_idx_r <= 2'h0;
    end else if (wr_fire && cmd_r == i2cr_pkg::OFS_LOCK && !unlocked_r) begin
      if (rx_r == i2cr_pkg::PASS_CODES[pass_idx_r]) begin
        if (pass_idx_r == 2'(i2cr_pkg::PASS_COUNT - 1)) begin
          unlocked_r <= 1'b1;
          pass_idx_r <= 2'h0;
        end else begin
          pass_idx_r <= pass_idx_r + 2'h1;
        end
      end else begin
        pass_idx_r <= 2'h0;
      end
    end
  end

  assign regs_unlocked = unlocked_r;

  ////////////////////////////////////////////////////////////////////////////
  // working copy, restores and writes
  logic restore_go;
  logic store_go;
  assign restore_go = init_go | (wr_fire & (cmd_r == i2cr_pkg::OFS_RESTORE));
  assign store_go = wr_fire & (cmd_r == i2cr_pkg::OFS_STORE) & rx_r[i2cr_pkg::STORE_GO];
  always_ff @(posedge clock) begin
    if (srst) begin
      work_r <= '0;
    end else if (restore_go) begin
      work_r <= nvm_rd_image;
      // always-on keeps the old timing and limit values
      if (always_on_mode) begin
        work_r.turn_on_delay <= work_r.turn_on_delay;
        work_r.turn_on_rise_time <= work_r.turn_on_rise_time;
        work_r.turn_off_delay <= work_r.turn_off_delay;
        work_r.turn_off_fall_time <= work_r.turn_off_fall_time;
        work_r.vmax_h <= work_r.vmax_h;
        work_r.vmax_l <= work_r.vmax_l;
      end
    end else if (wr_fire) begin
      // only the working copy changes; storing is separate
      case (cmd_r)
        i2cr_pkg::OFS_TURN_ON_DELAY: work_r.turn_on_delay <= rx_r;
        i2cr_pkg::OFS_TURN_ON_RISE_TIME: work_r.turn_on_rise_time <= rx_r;
        i2cr_pkg::OFS_TURN_OFF_DELAY: work_r.turn_off_delay <= rx_r;
        i2cr_pkg::OFS_TURN_OFF_FALL_TIME: work_r.turn_off_fall_time <= rx_r;
        i2cr_pkg::OFS_SYS_CFG: work_r.sys_cfg <= rx_r;
        i2cr_pkg::OFS_VID_ADDR: work_r.vid_addr <= rx_r;
        i2cr_pkg::OFS_TGT_ADDR: work_r.tgt_addr <= {1'b0, rx_r[6:0]};
        i2cr_pkg::OFS_VOUT_OFS: work_r.vout_ofs <= rx_r;
        i2cr_pkg::OFS_VMAX_H: work_r.vmax_h <= rx_r;
        i2cr_pkg::OFS_VMAX_L: work_r.vmax_l <= rx_r;
        i2cr_pkg::OFS_PROTO: work_r.proto <= rx_r;
        default: work_r <= work_r;
      endcase
    end
  end

  assign live_cfg = work_r;

  ////////////////////////////////////////////////////////////////////////////
  // staged fields, applied only while switching is off; the offset also while output control is not 01b
  always_ff @(posedge clock) begin
    if (srst) begin
      eff_cfg <= '0;
    end else begin
      // under always-on this may never fire and values stay staged
      if (!switching_enabled) begin
        eff_cfg.forced_continuous_flag <= work_r.sys_cfg[i2cr_pkg::SC_FORCED_CONTINUOUS_FLAG];
        eff_cfg.output_control_field <= work_r.sys_cfg[i2cr_pkg::SC_OUT_CTRL_LO +: 2];
        eff_cfg.soft_stop_enable <= work_r.sys_cfg[i2cr_pkg::SC_SOFT_STOP];
        eff_cfg.ready_output_delay <= work_r.sys_cfg[i2cr_pkg::SC_RDY_DLY_LO +: 2];
        eff_cfg.serial_vid_bus_address <= work_r.vid_addr;
        eff_cfg.broadcast_select <= work_r.proto[i2cr_pkg::PROTO_BCAST];
      end
      if (!switching_enabled ||
          eff_cfg.output_control_field != i2cr_pkg::OUT_CTRL_STAGED) begin
        eff_cfg.output_voltage_offset <= work_r.vout_ofs;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target address, loaded only on a restore, from restored contents or the captured strap
  logic addr_ovrd_r;
  logic vid_ovrd_r;
  logic [6:0] prog_addr_r;
  logic [6:0] strap_addr_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_ovrd_r <= 1'b0;
      vid_ovrd_r <= 1'b0;
      prog_addr_r <= 7'h00;
      strap_addr_r <= i2cr_pkg::STRAP_BASE_ADDR;
    end else if (restore_go) begin
      // a plain write never reaches these
      addr_ovrd_r <= nvm_rd_image.sys_cfg[i2cr_pkg::SC_ADDR_OVRD];
      vid_ovrd_r <= nvm_rd_image.sys_cfg[i2cr_pkg::SC_VID_OVRD];
      prog_addr_r <= nvm_rd_image.tgt_addr[6:0];
      if (init_go) begin
        strap_addr_r <= i2cr_pkg::STRAP_BASE_ADDR | {3'h0, strap_b};
      end
    end
  end

  assign target_address = addr_ovrd_r ? prog_addr_r : strap_addr_r;
  assign vid_address_override_flag = vid_ovrd_r;

  ////////////////////////////////////////////////////////////////////////////
  // store sequencing
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_cnt_r <= 26'h0;
      nvm_wr_req <= 1'b0;
      nvm_wr_image <= '0;
    end else begin
      nvm_wr_req <= store_go;
      if (store_go) begin
        nvm_wr_image <= work_r;
        busy_cnt_r <= STORE_CYCLES[25:0];
      end else if (busy_cnt_r != 26'h0) begin
        busy_cnt_r <= busy_cnt_r - 26'h1;
      end
    end
  end

  assign busy = (busy_cnt_r != 26'h0);
  assign nvm_busy = busy;

  ////////////////////////////////////////////////////////////////////////////
  // read side
  logic [7:0] temp_r;
  // controller die only; the power stage has no path here
  always_ff @(posedge clock) begin
    if (srst) begin
      temp_r <= i2cr_pkg::RESET_VALUE;
    end else begin
      temp_r <= die_temp_c + i2cr_pkg::TEMP_OFFSET;
    end
  end
  always_comb begin
    rdata = i2cr_pkg::RESET_VALUE;
    // staged fields read back their last accepted value
    case (cmd_r)
      i2cr_pkg::OFS_TURN_ON_DELAY: rdata = work_r.turn_on_delay;
      i2cr_pkg::OFS_TURN_ON_RISE_TIME: rdata = work_r.turn_on_rise_time;
      i2cr_pkg::OFS_TURN_OFF_DELAY: rdata = work_r.turn_off_delay;
      i2cr_pkg::OFS_TURN_OFF_FALL_TIME: rdata = work_r.turn_off_fall_time;
      i2cr_pkg::OFS_TEMP: rdata = temp_r;
      i2cr_pkg::OFS_SYS_CFG: rdata = work_r.sys_cfg;
      i2cr_pkg::OFS_VID_ADDR: rdata = work_r.vid_addr;
      i2cr_pkg::OFS_TGT_ADDR: rdata = work_r.tgt_addr;
      i2cr_pkg::OFS_VOUT_OFS: rdata = work_r.vout_ofs;
      i2cr_pkg::OFS_LOCK: rdata = {7'h00, unlocked_r};
      i2cr_pkg::OFS_VMAX_H: rdata = work_r.vmax_h;
      i2cr_pkg::OFS_VMAX_L: rdata = work_r.vmax_l;
      i2cr_pkg::OFS_PROTO: rdata = work_r.proto;
      default: rdata = i2cr_pkg::RESET_VALUE;
    endcase
  end

endmodule

// ==== tb/i2cr_checker.sv ====
// assertions on the pins of the serial register front end
`timescale 1ns/1ns
module i2cr_checker #(
  parameter int STORE_CYCLES = 50
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bus
  input wire logic scl_i,
  input wire logic sda_oe,
  // converter side
  input wire logic switching_enabled,
  // store
  input wire i2cr_pkg::i2cr_image_t nvm_wr_image,
  input wire logic nvm_wr_req,
  input wire logic nvm_busy,
  // configuration
  input wire i2cr_pkg::i2cr_image_t live_cfg,
  input wire i2cr_pkg::i2cr_eff_t eff_cfg,
  input wire logic regs_unlocked
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  int busy_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // length of the store window in cycles
  always_ff @(posedge clock) begin
    if (srst || !nvm_busy) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($fell(srst) |-> !sda_oe && !nvm_wr_req && !nvm_busy && !regs_unlocked)
    else $error("outputs not idle after reset");
  a_req_busy: assert property (nvm_wr_req |=> nvm_busy)
    else $error("store request without busy");
  a_one_store: assert property (nvm_busy && $past(nvm_busy) |-> !nvm_wr_req)
    else $error("store started while busy");
  a_busy_max: assert property (nvm_busy |-> busy_cnt_r <= STORE_CYCLES + 1)
    else $error("store window too long");
  a_busy_min: assert property ($fell(nvm_busy) |-> busy_cnt_r >= STORE_CYCLES - 1)
    else $error("store window too short");
  a_image_live: assert property (nvm_wr_req |-> nvm_wr_image == live_cfg)
    else $error("stored image differs from working copy");
  a_unlock_hold: assert property (regs_unlocked |=> regs_unlocked)
    else $error("lock returned without reset");
  // the offset may follow at once while output control is not 01b, so it is left out here
  a_stage_hold: assert property (switching_enabled && $past(switching_enabled) |->
    $stable({eff_cfg.forced_continuous_flag, eff_cfg.output_control_field,
    eff_cfg.soft_stop_enable, eff_cfg.ready_output_delay, eff_cfg.serial_vid_bus_address,
    eff_cfg.broadcast_select}))
    else $error("staged field changed while switching");
  a_stage_copy: assert property ((!switching_enabled && $stable(live_cfg)) [*3] |->
    eff_cfg.forced_continuous_flag == live_cfg.sys_cfg[2] &&
    eff_cfg.output_control_field == live_cfg.sys_cfg[4:3] &&
    eff_cfg.serial_vid_bus_address == live_cfg.vid_addr)
    else $error("staged fields not applied while idle");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2))
    else $error("data line moved while bus clock high");
endmodule

bind i2cr_top i2cr_checker #(.STORE_CYCLES(STORE_CYCLES)) i_chk (
  .clock(clock), .srst(srst), .scl_i(scl_i), .sda_oe(sda_oe),
  .switching_enabled(switching_enabled), .nvm_wr_image(nvm_wr_image),
  .nvm_wr_req(nvm_wr_req), .nvm_busy(nvm_busy), .live_cfg(live_cfg),
  .eff_cfg(eff_cfg), .regs_unlocked(regs_unlocked));

// ==== tb/i2cr_host.sv ====
// bit-level serial bus host driving the target's pins
`timescale 1ns/1ns
module i2cr_host (
  // clock
  input wire logic clock,
  // bus
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // 252 clocks a bit keeps the bus just under 1 MHz
  localparam int Q = 63;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic q_wait();
    repeat (Q) @(negedge clock);
  endtask

  // also serves as repeated start, scl is low between bytes
  task automatic start_bit();
    sda_low = 1'b0;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_low = 1'b1;
    q_wait();
    scl = 1'b0;
    q_wait();
  endtask

  // frames end here, no check byte appended
  task automatic stop_bit();
    sda_low = 1'b1;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_low = 1'b0;
    q_wait();
  endtask

  // data set mid-low, sampled mid-high: clear of the target's sync delay
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    q_wait();
    scl = 1'b1;
    q_wait();
    r = sda_line;
    q_wait();
    scl = 1'b0;
    q_wait();
  endtask

  // msb first, ninth bit sent as given and read back
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
                      output logic nr);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(nine, nr);
  endtask
endmodule

// ==== tb/tb_top.sv ====
// register-level bench for the serial register front end
`timescale 1ns/1ns
module tb_top;
  localparam int STORE_N = 9000;
  localparam logic [6:0] ADDR = 7'h75;

  logic clock, srst, sda_o, sda_oe, nvm_wr_req, nvm_busy, regs_unlocked, ack;
  logic switching_enabled, always_on_mode, vid_ovrd;
  logic [3:0] strap_level;
  logic [7:0] die_temp_c, v;
  logic [6:0] target_address;
  i2cr_pkg::i2cr_image_t nvm_wr_image, live_cfg;
  // power-on image: a timing value always-on must refuse, a plain value that must load
  i2cr_pkg::i2cr_image_t nvm_rd_image = '{turn_on_delay: 8'h3c, proto: 8'h01, default: 8'h00};
  i2cr_pkg::i2cr_eff_t eff_cfg;
  int miscompares = 0;
  int samples_checked = 0;
  int stores = 0;
  wire scl, host_low, sda_line;

  // open drain with pull-up
  assign sda_line = ~(host_low | (sda_oe & ~sda_o));

  i2cr_host i_host (.clock(clock), .scl(scl), .sda_low(host_low), .sda_line(sda_line));

  i2cr_top #(.STORE_CYCLES(STORE_N)) i_dut (.clock(clock), .srst(srst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .strap_level(strap_level),
    .switching_enabled(switching_enabled), .always_on_mode(always_on_mode),
    .die_temp_c(die_temp_c), .nvm_rd_image(nvm_rd_image), .nvm_wr_image(nvm_wr_image),
    .nvm_wr_req(nvm_wr_req), .nvm_busy(nvm_busy), .live_cfg(live_cfg), .eff_cfg(eff_cfg),
    .target_address(target_address), .vid_address_override_flag(vid_ovrd),
    .regs_unlocked(regs_unlocked));

  ////////////////////////////////////////////////////////////////////////////
  // memory stand-in: a store becomes the next restore's content
  always @(posedge clock) begin
    if (nvm_wr_req === 1'b1) begin
      nvm_rd_image <= nvm_wr_image;
      stores <= stores + 1;
    end
  end

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checked %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // all data bytes land in one register; ack is the last byte's answer
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d[$],
                    output logic ak);
    logic [7:0] q;
    logic n;
    i_host.start_bit();
    i_host.xfer({a, 1'b0}, 1'b1, q, n);
    i_host.xfer(r, 1'b1, q, n);
    foreach (d[i]) begin
      i_host.xfer(d[i], 1'b1, q, n);
    end
    ak = ~n;
    i_host.stop_bit();
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d);
    logic [7:0] q;
    logic n;
    i_host.start_bit();
    i_host.xfer({a, 1'b0}, 1'b1, q, n);
    i_host.xfer(r, 1'b1, q, n);
    i_host.start_bit();
    i_host.xfer({a, 1'b1}, 1'b1, q, n);
    check({7'h00, n}, 8'h00);
    i_host.xfer(8'hff, 1'b1, d, n);
    i_host.stop_bit();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (nvm_busy !== 1'b0 && n < 2 * STORE_N) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2 * STORE_N) begin
      miscompares++;
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    strap_level = 4'h5;
    switching_enabled = 1'b0;
    always_on_mode = 1'b1;
    die_temp_c = 8'h19;
    repeat (10) @(negedge clock);
    srst = 1'b0;
    repeat (10) @(negedge clock);
    always_on_mode = 1'b0;
    check({1'b0, target_address}, {1'b0, ADDR});
    check(live_cfg.turn_on_delay, 8'h00);
    check(live_cfg.proto, 8'h01);
    rd(ADDR, i2cr_pkg::OFS_TEMP, v);
    check(v, 8'h19 + i2cr_pkg::TEMP_OFFSET);
    wr(ADDR, i2cr_pkg::OFS_VOUT_OFS, '{8'h11}, ack);
    check({7'h00, ack}, 8'h00);
    check(live_cfg.vout_ofs, 8'h00);
    // a wrong code mid-sequence must start it over
    wr(ADDR, i2cr_pkg::OFS_LOCK, '{i2cr_pkg::PASS_CODES[0], 8'h33, i2cr_pkg::PASS_CODES[1]}, ack);
    check({7'h00, regs_unlocked}, 8'h00);
    wr(ADDR, i2cr_pkg::OFS_LOCK, '{i2cr_pkg::PASS_CODES[0], i2cr_pkg::PASS_CODES[1]}, ack);
    check({7'h00, regs_unlocked}, 8'h01);
    switching_enabled = 1'b1;
    wr(ADDR, i2cr_pkg::OFS_TURN_ON_DELAY, '{8'h3c}, ack);
    check({7'h00, ack}, 8'h00);
    check(live_cfg.turn_on_delay, 8'h00);
    wr(ADDR, i2cr_pkg::OFS_SYS_CFG, '{8'h07}, ack);
    check({7'h00, ack}, 8'h01);
    check({7'h00, eff_cfg.forced_continuous_flag}, 8'h00);
    rd(ADDR, i2cr_pkg::OFS_SYS_CFG, v);
    check(v, 8'h07);
    switching_enabled = 1'b0;
    repeat (4) @(negedge clock);
    check({7'h00, eff_cfg.forced_continuous_flag}, 8'h01);
    wr(ADDR, i2cr_pkg::OFS_TGT_ADDR, '{8'h15}, ack);
    check({vid_ovrd, target_address}, {1'b0, ADDR});
    wr(ADDR, i2cr_pkg::OFS_STORE, '{8'h01}, ack);
    check({7'h00, nvm_busy}, 8'h01);
    check(nvm_rd_image.tgt_addr, 8'h15);
    check(nvm_rd_image.sys_cfg, 8'h07);
    wr(ADDR, i2cr_pkg::OFS_STORE, '{8'h01}, ack);
    check({7'h00, ack}, 8'h00);
    check(stores[7:0], 8'h01);
    // host waits out the store before reloading
    wait_idle();
    wr(ADDR, i2cr_pkg::OFS_RESTORE, '{8'h00}, ack);
    check({7'h00, ack}, 8'h01);
    repeat (4) @(negedge clock);
    check({vid_ovrd, target_address}, 8'h95);
    print_verdict();
  end
endmodule
